/* hdl/qsf_consts.svh */
// Constants for the quad serial configuration flash link
`ifndef QSF_CONSTS_SVH
`define QSF_CONSTS_SVH
`define QSF_OP_READ         8'h03
`define QSF_OP_DREAD        8'h3b
`define QSF_OP_QREAD        8'h6b
`define QSF_OP_PROG         8'h02
`define QSF_OP_QPROG        8'h32
`define QSF_OP_SSERASE      8'h20
`define QSF_OP_SERASE       8'hd8
`define QSF_OP_STATUS       8'h05
`define QSF_OP_BITS         6'd8
`define QSF_HDR_BITS        6'd32
`define QSF_PAGE_BYTES      256
`define QSF_SUBSECTOR_BYTES 4096
`define QSF_SECTOR_BYTES    65536
`define QSF_ERASED_BYTE     8'hff
`define QSF_STATUS_BUSY_BIT 0
`define QSF_REF_CLK_MHZ     200
`define QSF_RESET_MIN_NS    1000
`define QSF_RESET_CYCLES    ((`QSF_RESET_MIN_NS * `QSF_REF_CLK_MHZ + 999) / 1000)
`define QSF_DESEL_CYCLES    8
`define QSF_MIN_ADDR_BITS   19
`define QSF_QUAD_ADDR_BITS  20
`define QSF_MAX_ADDR_BITS   24
`endif

/* hdl/qsf_pkg.sv */
// Types and opcode decoding shared by both ends of the flash link
package qsf_pkg;
  `include "qsf_consts.svh"

  typedef struct packed {
    logic       known;
    logic       rd;
    logic       wr;
    logic       er;
    logic       st;
    logic [2:0] lines;
  } qsf_op_t;

  typedef enum logic [2:0] {
    QSF_C_IDLE  = 3'b001,
    QSF_C_PROG  = 3'b010,
    QSF_C_ERASE = 3'b100
  } qsf_core_state_t;

  typedef enum logic [6:0] {
    QSF_H_RST   = 7'b0000001,
    QSF_H_WAKE  = 7'b0000010,
    QSF_H_GAP   = 7'b0000100,
    QSF_H_IDLE  = 7'b0001000,
    QSF_H_LEAD  = 7'b0010000,
    QSF_H_SHIFT = 7'b0100000,
    QSF_H_TAIL  = 7'b1000000
  } qsf_host_state_t;

  // Opcode classes; four-line opcodes vanish on parts without them
  function automatic qsf_op_t qsf_decode(input logic [7:0] op, input logic quad_ok);
    qsf_op_t d;
    d = '0;
    d.lines = 3'd1;
    d.known = 1'b1;
    case (op)
      `QSF_OP_READ:    d.rd = 1'b1;
      `QSF_OP_DREAD:
      begin
        d.rd = 1'b1;
        d.lines = 3'd2;
      end
      `QSF_OP_QREAD:
      begin
        d.rd = 1'b1;
        d.lines = 3'd4;
        d.known = quad_ok;
      end
      `QSF_OP_PROG:    d.wr = 1'b1;
      `QSF_OP_QPROG:
      begin
        d.wr = 1'b1;
        d.lines = 3'd4;
        d.known = quad_ok;
      end
      `QSF_OP_SSERASE: d.er = 1'b1;
      `QSF_OP_SERASE:  d.er = 1'b1;
      `QSF_OP_STATUS:  d.st = 1'b1;
      default:         d.known = 1'b0;
    endcase
    return d;
  endfunction
endpackage

/* hdl/qsf_link_if.sv */
// Pin bundle between the flash device and its controller
`timescale 1ns/1ps
interface qsf_link_if;
  logic       sclk;
  logic       select_n;
  logic       hw_reset_n;
  logic [3:0] host_out;
  logic [3:0] host_oe_n;
  logic [3:0] dev_out;
  logic [3:0] dev_oe_n;
  logic [3:0] io;

  // Wire level of each data line; nobody driving means the board pull-up
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      io[i] = !dev_oe_n[i] ? dev_out[i] : (!host_oe_n[i] ? host_out[i] : 1'b1);
    end
  end

  modport dev  (input sclk, select_n, hw_reset_n, io, output dev_out, dev_oe_n);
  modport host (input io, output sclk, select_n, hw_reset_n, host_out, host_oe_n);
endinterface

/* hdl/qsf_device.sv */
// Serial flash device end: link shifter on the serial clock, array engine on ref_clk
// Notes on behaviour
// - Inputs sampled on rising serial clock edges.
// - Outputs change after falling edge; captured next fall.
// - Deselected device releases all four data lines.
// - Active only while select low, one operation each.
// - Controller makes a select falling edge first.
// - Reset low about one microsecond aborts everything.
// - Single-line mode: line 0 carries input.
// - Line 1 drives read data out.
// - Four-line mode: line 0 bidirectional by phase.
// - Quad page write: all four lines inputs.
// - Dual read: lines 0, 1 drive data.
// - Quad read: lines 2, 3 drive too.
// - Single-line mode holds lines 2, 3 high.
// - Smallest density: no four-line transfers.
// - Sectors of 64 KB, sixteen 4 KB subsectors.
// - Pages of 256 bytes, 256 per sector.
// - Array erased, unprogrammed bits read one.
// - All fields shifted most significant bit first.
// - Write or erase needs whole bytes, else rejected.
// - Access other than status during write or erase is rejected.
`timescale 1ns/1ps
`include "qsf_consts.svh"
module qsf_device
  import qsf_pkg::*;
#(
  parameter int ADDR_BITS    = `QSF_MAX_ADDR_BITS,
  parameter int RESET_CYCLES = `QSF_RESET_CYCLES
)
(
  input  wire logic ref_clk,
  input  wire logic reset,
  qsf_link_if.dev   link,
  output logic      busy,
  output logic      awake
);
  import qsf_pkg::*;

  localparam int  AB       = ADDR_BITS;
  localparam bit  QUAD_OK  = ADDR_BITS >= `QSF_QUAD_ADDR_BITS;
  localparam int  PAGE_LOG = $clog2(`QSF_PAGE_BYTES);
  localparam int  SUB_LOG  = $clog2(`QSF_SUBSECTOR_BYTES);
  localparam int  SEC_LOG  = $clog2(`QSF_SECTOR_BYTES);

  generate
    if (ADDR_BITS < `QSF_MIN_ADDR_BITS || ADDR_BITS > `QSF_MAX_ADDR_BITS || RESET_CYCLES < 1)
    begin : g_bad
      $error("qsf_device: unsupported ADDR_BITS or RESET_CYCLES");
    end
  endgenerate

  logic [7:0]               mem  [1 << AB];
  logic [7:0]               pbuf [`QSF_PAGE_BYTES];
  logic [`QSF_PAGE_BYTES-1:0] pvalid, next_pvalid;
  logic [5:0]               cnt, next_cnt;
  logic [2:0]               bitpos, next_bitpos;
  logic [7:0]               in_byte, next_in_byte, opcode, next_opcode;
  logic                     rejected, next_rejected, armed, next_armed;
  logic                     frame_tog, next_tog, pb_we;
  logic [23:0]              addr, next_addr;
  logic [AB-1:0]            cur_addr, next_cur_addr;
  logic [3:0]               out_val, next_out_val, out_oe_n, next_out_oe_n;
  logic [1:0]               awake_s, busy_s;
  qsf_op_t                  dec, new_dec;
  logic                     hdr_done, link_rst, frame_rst;
  logic [7:0]               status, rd_byte, shifted;
  logic [1:0]               sel_s, rst_s, arm_s, tog_s;
  logic                     sel_d, abort, next_abort, done_tog, next_done;
  logic                     next_busy, next_awake;
  logic [15:0]              low_cnt, next_low;
  qsf_core_state_t          state, next_state;
  logic [16:0]              ecnt, next_ecnt, elast, next_elast;
  logic [AB-1:0]            base, next_base, mem_wa;
  logic                     mem_we;
  logic [7:0]               mem_wd;

  // Delivered state is fully erased
  initial
  begin
    for (int i = 0; i < (1 << AB); i++)
    begin
      mem[i] = `QSF_ERASED_BYTE;
    end
  end

  // Resets are combinational; select high holds the shifter cleared
  assign link_rst  = reset | abort;
  assign frame_rst = link_rst | link.select_n;
  assign dec       = qsf_decode(opcode, QUAD_OK);
  assign new_dec   = qsf_decode(next_opcode, QUAD_OK);
  assign hdr_done  = (cnt == `QSF_HDR_BITS) || (cnt == `QSF_OP_BITS && dec.st);
  assign status    = 8'((busy_s[1] ? 1 : 0) << `QSF_STATUS_BUSY_BIT);

  // Link shifter: opcode, address, then data, all on rising edges
  always_comb
  begin
    next_cnt      = cnt;
    next_bitpos   = bitpos;
    next_in_byte  = in_byte;
    next_rejected = rejected;
    next_opcode   = opcode;
    next_addr     = addr;
    next_cur_addr = cur_addr;
    next_tog      = frame_tog;
    next_pvalid   = pvalid;
    next_armed    = armed;
    pb_we         = 1'b0;
    if (!link.select_n)
    begin
      if (cnt == 6'd0)
        next_tog = ~frame_tog;
      if (!hdr_done)
        next_cnt = cnt + 6'd1;
      if (cnt < `QSF_OP_BITS)
        next_opcode = {opcode[6:0], link.io[0]};
      else if (!hdr_done)
        next_addr = {addr[22:0], link.io[0]};
      // Unknown op, not yet woken, or array busy on a non-status op: whole frame refused
      if (cnt == `QSF_OP_BITS - 6'd1)
        next_rejected = !new_dec.known || !awake_s[1] || (busy_s[1] && !new_dec.st);
      if (cnt == `QSF_HDR_BITS - 6'd1 && !rejected)
      begin
        next_cur_addr = next_addr[AB-1:0];
        next_pvalid   = '0;
      end
      if (hdr_done && !rejected)
      begin
        next_bitpos = bitpos + dec.lines;
        case (dec.lines)
          3'd4:    next_in_byte = {in_byte[3:0], link.io};
          3'd2:    next_in_byte = {in_byte[5:0], link.io[1:0]};
          default: next_in_byte = {in_byte[6:0], link.io[0]};
        endcase
        if (next_bitpos == 3'd0 && dec.rd)
          next_cur_addr = cur_addr + 1'b1;
        if (next_bitpos == 3'd0 && dec.wr)
        begin
          pb_we = 1'b1;
          next_pvalid[cur_addr[PAGE_LOG-1:0]] = 1'b1;
          // Page write wraps within its page
          next_cur_addr = {cur_addr[AB-1:PAGE_LOG], cur_addr[PAGE_LOG-1:0] + 8'h01};
        end
      end
      // Armed only on a byte boundary after a full header
      next_armed = (dec.wr || dec.er) && !next_rejected && next_cnt == `QSF_HDR_BITS
                   && next_bitpos == 3'd0;
    end
  end

  // Per-frame state, cleared whenever select is high
  always_ff @(posedge link.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      cnt      <= 6'd0;
      bitpos   <= 3'd0;
      in_byte  <= 8'h00;
      rejected <= 1'b0;
    end
    else
    begin
      cnt      <= next_cnt;
      bitpos   <= next_bitpos;
      in_byte  <= next_in_byte;
      rejected <= next_rejected;
    end
  end

  // State that the array engine reads after the frame ends
  always_ff @(posedge link.sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      opcode    <= 8'h00;
      addr      <= 24'h000000;
      cur_addr  <= '0;
      armed     <= 1'b0;
      frame_tog <= 1'b0;
      pvalid    <= '0;
      awake_s   <= 2'b00;
      busy_s    <= 2'b00;
    end
    else
    begin
      opcode    <= next_opcode;
      addr      <= next_addr;
      cur_addr  <= next_cur_addr;
      armed     <= next_armed;
      frame_tog <= next_tog;
      pvalid    <= next_pvalid;
      awake_s   <= {awake_s[0], awake};
      busy_s    <= {busy_s[0], busy};
    end
  end

  // Page buffer, no reset
  always_ff @(posedge link.sclk)
  begin
    if (pb_we)
      pbuf[cur_addr[PAGE_LOG-1:0]] <= next_in_byte;
  end

  // Output lines: array is quasi-static here since reads are refused while busy
  always_comb
  begin
    rd_byte       = dec.st ? status : mem[cur_addr];
    shifted       = rd_byte << bitpos;
    next_out_val  = 4'h0;
    next_out_oe_n = 4'hf;
    if (hdr_done && !rejected && (dec.rd || dec.st))
    begin
      case (dec.lines)
        3'd4:
        begin
          next_out_val  = shifted[7:4];
          next_out_oe_n = 4'h0;
        end
        3'd2:
        begin
          next_out_val  = {2'b00, shifted[7:6]};
          next_out_oe_n = 4'hc;
        end
        default:
        begin
          next_out_val  = {2'b00, shifted[7], 1'b0};
          next_out_oe_n = 4'hd;
        end
      endcase
    end
  end

  // Driven lines change on falling edges; select high releases them at once
  always_ff @(negedge link.sclk or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      out_val  <= 4'h0;
      out_oe_n <= 4'hf;
    end
    else
    begin
      out_val  <= next_out_val;
      out_oe_n <= next_out_oe_n;
    end
  end

  assign link.dev_out  = out_val;
  assign link.dev_oe_n = out_oe_n;

  // Synchronisers into ref_clk
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sel_s <= 2'b11;
      rst_s <= 2'b11;
      arm_s <= 2'b00;
      tog_s <= 2'b00;
      sel_d <= 1'b1;
    end
    else
    begin
      sel_s <= {sel_s[0], link.select_n};
      rst_s <= {rst_s[0], link.hw_reset_n};
      arm_s <= {arm_s[0], armed};
      tog_s <= {tog_s[0], frame_tog};
      sel_d <= sel_s[1];
    end
  end

  // Array engine: starts on select rising, one byte per ref_clk
  always_comb
  begin
    next_state = state;
    next_ecnt  = ecnt + 17'd1;
    next_elast = elast;
    next_base  = base;
    next_done  = done_tog;
    next_low   = rst_s[1] ? 16'd0 : (low_cnt == 16'(RESET_CYCLES) ? low_cnt : low_cnt + 16'd1);
    next_abort = next_low == 16'(RESET_CYCLES);
    next_awake = !abort && (awake || sel_s[1]);
    mem_we     = 1'b0;
    mem_wa     = base | AB'(ecnt);
    mem_wd     = `QSF_ERASED_BYTE;
    // Every frame end takes up its toggle, reads too, so only a fresh armed frame can start the engine
    if (sel_s[1] && !sel_d)
      next_done = tog_s[1];
    case (state)
      QSF_C_IDLE:
      begin
        next_ecnt = 17'd0;
        if (sel_s[1] && !sel_d && arm_s[1] && tog_s[1] != done_tog)
        begin
          if (dec.wr)
          begin
            next_state = QSF_C_PROG;
            next_base  = {addr[AB-1:PAGE_LOG], PAGE_LOG'(0)};
            next_elast = 17'(`QSF_PAGE_BYTES - 1);
          end
          else if (opcode == `QSF_OP_SSERASE)
          begin
            next_state = QSF_C_ERASE;
            next_base  = {addr[AB-1:SUB_LOG], SUB_LOG'(0)};
            next_elast = 17'(`QSF_SUBSECTOR_BYTES - 1);
          end
          else
          begin
            next_state = QSF_C_ERASE;
            next_base  = {addr[AB-1:SEC_LOG], SEC_LOG'(0)};
            next_elast = 17'(`QSF_SECTOR_BYTES - 1);
          end
        end
      end
      QSF_C_PROG:
      begin
        // Programming only clears bits; untouched bytes are skipped
        mem_we = pvalid[ecnt[PAGE_LOG-1:0]];
        mem_wd = mem[mem_wa] & pbuf[ecnt[PAGE_LOG-1:0]];
        if (ecnt == elast)
          next_state = QSF_C_IDLE;
      end
      QSF_C_ERASE:
      begin
        mem_we = 1'b1;
        if (ecnt == elast)
          next_state = QSF_C_IDLE;
      end
      default: next_state = QSF_C_IDLE;
    endcase
    if (abort)
      next_state = QSF_C_IDLE;
    next_busy = next_state != QSF_C_IDLE;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state    <= QSF_C_IDLE;
      ecnt     <= 17'd0;
      elast    <= 17'd0;
      base     <= '0;
      done_tog <= 1'b0;
      low_cnt  <= 16'd0;
      abort    <= 1'b0;
      busy     <= 1'b0;
      awake    <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      ecnt     <= next_ecnt;
      elast    <= next_elast;
      base     <= next_base;
      done_tog <= next_done;
      low_cnt  <= next_low;
      abort    <= next_abort;
      busy     <= next_busy;
      awake    <= next_awake;
    end
  end

  // Array write port
  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end
endmodule

/* hdl/qsf_host.sv */
// Flash controller end: makes the serial clock and frames one command at a time
`timescale 1ns/1ps
`include "qsf_consts.svh"
module qsf_host
  import qsf_pkg::*;
#(
  parameter int DIV        = 3,
  parameter int RESET_HOLD = `QSF_RESET_CYCLES,
  parameter bit QUAD_OK    = 1'b1
)
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  qsf_link_if.host        link,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_op,
  input  wire logic [23:0] cmd_addr,
  input  wire logic [8:0] cmd_len,
  output logic            cmd_ready,
  input  wire logic [7:0] wr_data,
  output logic            wr_take,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done,
  input  wire logic       reset_req
);
  import qsf_pkg::*;

  generate
    if (DIV < 3 || DIV > 255 || RESET_HOLD < 1 || RESET_HOLD > 65535)
    begin : g_bad
      $error("qsf_host: DIV or RESET_HOLD out of range");
    end
  endgenerate

  qsf_host_state_t state, n_state;
  qsf_op_t         d, n_d, cd;
  logic [7:0]      div_cnt, tx, n_tx, rx, n_rx, n_rd_data, sh;
  logic [15:0]     hold, n_hold;
  logic            sclk, n_sclk, sel_n, n_sel_n, rst_n, n_rst_n, tick;
  logic            n_cmd_ready, n_wr_take, n_rd_valid, n_done;
  logic [3:0]      oval, n_oval, oe_n, n_oe_n, io_s1, io_s2;
  logic [11:0]     ecnt, n_ecnt, tot, n_tot, dbits;
  logic [5:0]      hlen, n_hlen;
  logic [31:0]     hsr, n_hsr;
  logic [2:0]      txpos, n_txpos, rxpos, n_rxpos;

  assign tick = div_cnt == 8'(DIV - 1);
  assign cd   = qsf_decode(cmd_op, QUAD_OK);

  always_comb
  begin
    n_state = state; n_d = d; n_tx = tx; n_rx = rx; n_rd_data = rd_data;
    n_hold = hold; n_sclk = sclk; n_sel_n = sel_n; n_rst_n = rst_n;
    n_cmd_ready = cmd_ready; n_wr_take = 1'b0; n_rd_valid = 1'b0; n_done = 1'b0;
    n_oval = oval; n_oe_n = oe_n; n_ecnt = ecnt; n_tot = tot; n_hlen = hlen;
    n_hsr = hsr; n_txpos = txpos; n_rxpos = rxpos;
    sh = (txpos == 3'd0 ? wr_data : tx) << txpos;
    dbits = (cd.rd || cd.wr || cd.st) ? ({cmd_len, 3'b000} >> (cd.lines >> 1)) : 12'd0;
    case (state)
      QSF_H_RST:
      begin
        n_hold = hold + 16'd1;
        if (hold == 16'(RESET_HOLD - 1))
        begin
          n_rst_n = 1'b1;
          n_state = QSF_H_WAKE;
        end
      end
      QSF_H_WAKE:
      begin
        // One select pulse after power-up or reset
        n_sel_n = 1'b0;
        n_hold  = 16'd0;
        if (tick && !sel_n)
        begin
          n_sel_n = 1'b1;
          n_state = QSF_H_GAP;
        end
      end
      QSF_H_GAP:
      begin
        n_hold = hold + 16'd1;
        if (hold == 16'(`QSF_DESEL_CYCLES - 1))
        begin
          n_state     = QSF_H_IDLE;
          n_cmd_ready = 1'b1;
        end
      end
      QSF_H_IDLE:
      begin
        n_hold = 16'd0;
        if (reset_req)
        begin
          n_rst_n = 1'b0; n_cmd_ready = 1'b0; n_state = QSF_H_RST;
        end
        else if (cmd_valid)
        begin
          n_d = cd; n_cmd_ready = 1'b0; n_state = QSF_H_LEAD;
          n_hlen = cd.st ? `QSF_OP_BITS : `QSF_HDR_BITS;
          n_tot  = 12'(n_hlen) + dbits;
          n_ecnt = 12'd0; n_txpos = 3'd0; n_rxpos = 3'd0;
          n_sel_n = 1'b0;
          n_oval = {3'b000, cmd_op[7]};
          n_oe_n = 4'he;
          n_hsr  = {cmd_op[6:0], cmd_addr, 1'b0};
        end
      end
      QSF_H_LEAD:
      begin
        if (tick)
        begin
          n_sclk = 1'b1; n_ecnt = ecnt + 12'd1; n_state = QSF_H_SHIFT;
        end
      end
      QSF_H_SHIFT:
      begin
        if (tick && !sclk)
        begin
          n_sclk = 1'b1; n_ecnt = ecnt + 12'd1;
        end
        else if (tick)
        begin
          n_sclk = 1'b0;
          // Capture on falling edge what the device set one fall earlier
          if ((d.rd || d.st) && ecnt > 12'(hlen))
          begin
            case (d.lines)
              3'd4:    n_rx = {rx[3:0], io_s2};
              3'd2:    n_rx = {rx[5:0], io_s2[1:0]};
              default: n_rx = {rx[6:0], io_s2[1]};
            endcase
            n_rxpos = rxpos + d.lines;
            if (n_rxpos == 3'd0)
            begin
              n_rd_data = n_rx; n_rd_valid = 1'b1;
            end
          end
          n_oe_n = 4'hf;
          if (ecnt == tot)
            n_state = QSF_H_TAIL;
          else if (ecnt < 12'(hlen))
          begin
            n_oval = {3'b000, hsr[31]}; n_oe_n = 4'he; n_hsr = {hsr[30:0], 1'b0};
          end
          else if (d.wr)
          begin
            n_wr_take = txpos == 3'd0;
            n_tx = txpos == 3'd0 ? wr_data : tx;
            n_txpos = txpos + d.lines;
            n_oval = d.lines == 3'd4 ? sh[7:4] : {3'b000, sh[7]};
            n_oe_n = d.lines == 3'd4 ? 4'h0 : 4'he;
          end
        end
      end
      QSF_H_TAIL:
      begin
        if (tick)
        begin
          n_sel_n = 1'b1; n_done = 1'b1; n_state = QSF_H_GAP;
        end
      end
      default: n_state = QSF_H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= QSF_H_WAKE; d <= '0; tx <= 8'h00; rx <= 8'h00; rd_data <= 8'h00;
      hold <= 16'd0; sclk <= 1'b0; sel_n <= 1'b1; rst_n <= 1'b1; cmd_ready <= 1'b0;
      wr_take <= 1'b0; rd_valid <= 1'b0; done <= 1'b0; oval <= 4'h0; oe_n <= 4'hf;
      ecnt <= 12'd0; tot <= 12'd0; hlen <= 6'd0; hsr <= 32'h00000000;
      txpos <= 3'd0; rxpos <= 3'd0; div_cnt <= 8'h00; io_s1 <= 4'hf; io_s2 <= 4'hf;
    end
    else
    begin
      state <= n_state; d <= n_d; tx <= n_tx; rx <= n_rx; rd_data <= n_rd_data;
      hold <= n_hold; sclk <= n_sclk; sel_n <= n_sel_n; rst_n <= n_rst_n; cmd_ready <= n_cmd_ready;
      wr_take <= n_wr_take; rd_valid <= n_rd_valid; done <= n_done; oval <= n_oval; oe_n <= n_oe_n;
      ecnt <= n_ecnt; tot <= n_tot; hlen <= n_hlen; hsr <= n_hsr;
      txpos <= n_txpos; rxpos <= n_rxpos; div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      io_s1 <= link.io; io_s2 <= io_s1;
    end
  end

  assign link.sclk       = sclk;
  assign link.select_n   = sel_n;
  assign link.hw_reset_n = rst_n;
  assign link.host_out   = oval;
  assign link.host_oe_n  = oe_n; // lines 2,3 driven only in quad write
endmodule

/* sim/qsf_link_sva.sv */
// Pin checker for the flash link
`timescale 1ns/1ps
module qsf_link_sva #(
  parameter int RESET_CYCLES = 8
)
(
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       sclk,
  input wire logic       select_n,
  input wire logic       hw_reset_n,
  input wire logic [3:0] host_out,
  input wire logic [3:0] host_oe_n,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe_n
);
  int low_cnt;
  // Length of a hardware reset pulse
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      low_cnt <= 0;
    else
      low_cnt <= hw_reset_n ? 0 : low_cnt + 1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_desel_release: assert property (select_n && $past(select_n) |-> dev_oe_n == 4'hf)
    else $error("device drives while deselected");
  chk_out_on_fall: assert property (!select_n && $changed(dev_out) |-> $fell(sclk))
    else $error("device output moved off a falling edge");
  chk_no_clash: assert property ((dev_oe_n | host_oe_n) == 4'hf)
    else $error("both ends drive one line");
  chk_sclk_idle: assert property (select_n |-> !sclk)
    else $error("serial clock runs while deselected");
  chk_host_setup: assert property (!select_n && $rose(sclk) |-> $stable(host_out))
    else $error("host data moved at rising edge");
  // Pulse must outlast the abort count plus the device's two-flop synchroniser
  chk_reset_abort: assert property ($rose(hw_reset_n) |-> low_cnt >= RESET_CYCLES + 2)
    else $error("hardware reset pulse too short");
  // Single-line phases leave the upper lines to the pull-up
  chk_x1_upper_high: assert property (!select_n && host_oe_n[1] && dev_oe_n[1] |-> host_oe_n[3:2] == 2'b11)
    else $error("host drives upper lines in single-line phase");
  chk_sclk_pace: assert property ($rose(sclk) |-> sclk [*3] ##1 !sclk)
    else $error("serial clock high phase wrong");
  chk_reset_desel: assert property (!hw_reset_n |-> select_n)
    else $error("select low during reset");
  cover property (!select_n && dev_oe_n == 4'h0);
  cover property (dev_oe_n == 4'hc);
  cover property (!hw_reset_n);
endmodule

/* sim/tb_top.sv */
// Bench joining controller and device over the link
`timescale 1ns/1ps
`include "qsf_consts.svh"
module tb_top;
  logic        ref_clk, reset, cmd_valid, cmd_ready, reset_req;
  logic        wr_take, rd_valid, done, busy, awake;
  logic [7:0]  cmd_op, wr_data, rd_data;
  logic [23:0] cmd_addr;
  logic [8:0]  cmd_len;
  int          failures, checked;
  logic [7:0]  wq[$], rq[$];

  qsf_link_if link ();
  qsf_device #(.ADDR_BITS(20), .RESET_CYCLES(8)) qsf_device_inst (.ref_clk, .reset, .link, .busy, .awake);
  qsf_host #(.RESET_HOLD(10)) qsf_host_inst (.ref_clk, .reset, .link, .cmd_valid, .cmd_op, .cmd_addr,
    .cmd_len, .cmd_ready, .wr_data, .wr_take, .rd_data, .rd_valid, .done, .reset_req);
  qsf_link_sva #(.RESET_CYCLES(8)) qsf_link_sva_inst (.ref_clk, .reset, .sclk(link.sclk),
    .select_n(link.select_n), .hw_reset_n(link.hw_reset_n), .host_out(link.host_out),
    .host_oe_n(link.host_oe_n), .dev_out(link.dev_out), .dev_oe_n(link.dev_oe_n));

  // 200 MHz reference
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wait_ready;
    while (cmd_ready !== 1'b1)
      @(negedge ref_clk);
  endtask

  // One command; write bytes from wq, read bytes into rq
  task automatic xfer(input logic [7:0] op, input logic [23:0] addr, input logic [8:0] len);
    rq = {};
    wait_ready();
    cmd_op = op;
    cmd_addr = addr;
    cmd_len = len;
    wr_data = wq.size() ? wq.pop_front() : 8'h00;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1)
    begin
      @(negedge ref_clk);
      if (rd_valid === 1'b1)
        rq.push_back(rd_data);
      if (wr_take === 1'b1 && wq.size())
        wr_data = wq.pop_front();
    end
  endtask

  // Busy sync takes a few cycles to show
  task automatic wait_idle;
    repeat (8) @(negedge ref_clk);
    while (busy !== 1'b0)
      @(negedge ref_clk);
  endtask

  initial
  begin
    failures = 0;
    checked = 0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_addr = 24'h000000;
    cmd_len = 9'h000;
    wr_data = 8'h00;
    reset_req = 1'b0;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    xfer(`QSF_OP_READ, 24'h000100, 9'h002);
    check(rq[1], 8'hff);
    wq = {8'h12, 8'h34, 8'h56, 8'h78};
    xfer(`QSF_OP_PROG, 24'h0001fe, 9'h004);
    wait_idle();
    xfer(`QSF_OP_READ, 24'h000100, 9'h002);
    check(rq[1], 8'h78);
    xfer(`QSF_OP_DREAD, 24'h0001fe, 9'h002);
    check(rq[0], 8'h12);
    wq = {8'ha5, 8'h3c};
    xfer(`QSF_OP_QPROG, 24'h000200, 9'h002);
    wait_idle();
    wq = {8'h0f};
    xfer(`QSF_OP_PROG, 24'h000200, 9'h001);
    wait_idle();
    xfer(`QSF_OP_QREAD, 24'h000200, 9'h003);
    check(rq[0], 8'h05);
    check(rq[1], 8'h3c);
    check(rq[2], 8'hff);
    xfer(`QSF_OP_SSERASE, 24'h001234, 9'h000);
    xfer(`QSF_OP_STATUS, 24'h000000, 9'h001);
    check({7'h00, rq[0][0]}, 8'h01);
    xfer(`QSF_OP_READ, 24'h000200, 9'h001);
    check(rq[0], 8'hff);
    wait_idle();
    xfer(`QSF_OP_READ, 24'h000200, 9'h001);
    check(rq[0], 8'h05);
    // Hardware reset in the middle of an erase
    xfer(`QSF_OP_SSERASE, 24'h000000, 9'h000);
    wait_ready();
    reset_req = 1'b1;
    @(negedge ref_clk);
    reset_req = 1'b0;
    wait_ready();
    check({7'h00, busy}, 8'h00);
    check({7'h00, awake}, 8'h01);
    xfer(`QSF_OP_SERASE, 24'h00ff00, 9'h000);
    wait_idle();
    xfer(`QSF_OP_READ, 24'h0001fe, 9'h001);
    check(rq[0], 8'hff);
    check({4'h0, link.io}, 8'h0f);
    results();
  end

  // Whole run is near 74k cycles
  initial
  begin
    #500000;
    failures++;
    results();
  end
endmodule
